//--- hdl/ccx_pkg.sv
// Constants, types and carriers of the completion credit tracker
//
// Overview of operation
// - Limit method: headers per maximum read = ceil(max request / RCB).
// - Request limit = min(data space / max request, headers / per-read).
// - Limit method: one pending counter, zero at reset, never above limit.
// - Counter steps at send, steps back once all completions arrived.
// - Header need = ceil((start mod RCB + size) / RCB).
// - Data need = ceil((start mod 16 + size) / 16); I/O writes need none.
// - Send only if both pending plus need fit totals; add and remember.
// - Per-packet: subtract remembered needs after the last completion.
// - Per-boundary: data reserve = header need times credits per boundary.
// - Per-boundary: free one header and one boundary of data per crossing.
// - Crossings = ceil((lower address mod RCB + length) / RCB).
// - Optional: I/O read reserves one data credit, I/O write none.
// - With that policy, completion tag finds the original request type.
// - Per-data: free one header per RCB crossing of each completion.
// - Per-data: free one data credit per 16-byte granule crossed.
// - Address-counter stepping may replace the closed-form crossing count.
// - Data credits may be scaled by 2 or 4 for finer granularity.
// - RCB select bit: 0 is 64 bytes, 1 is 128; default 64.
// - Max request field 000b to 101b is 128 to 4096 bytes; default 128.
// - Issue non-posted requests only when completion space exists.
package ccx_pkg;

  // ****************************************
  // Completion space and config decoding
  // ****************************************
  localparam logic [8:0]  CCX_TOTAL_HDR      = 9'h040;
  localparam logic [15:0] CCX_DATA_BYTES_GOOD = 16'h1f00;
  localparam logic [15:0] CCX_DATA_BYTES_HIGH = 16'h3e00;
  localparam logic [2:0]  CCX_CRED_LOG2      = 3'h4;
  localparam logic [2:0]  CCX_RCB_LOG2_MIN   = 3'h6;
  localparam logic [3:0]  CCX_MRS_LOG2_MIN   = 4'h7;
  localparam logic [2:0]  CCX_MRS_FIELD_MAX  = 3'h5;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  CCX_OFS_CTRL  = 8'h00;
  localparam logic [7:0]  CCX_OFS_REQ   = 8'h04;
  localparam logic [7:0]  CCX_OFS_HDR   = 8'h08;
  localparam logic [7:0]  CCX_OFS_DATA  = 8'h0c;
  localparam logic [7:0]  CCX_OFS_LIMIT = 8'h10;
  localparam int          CCX_CTRL_RCB  = 0;
  localparam int          CCX_CTRL_MRS  = 1;
  localparam int          CCX_CTRL_PERF = 4;
  localparam logic [4:0]  CCX_CTRL_RST  = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    CCX_OUTSTANDING_LIMIT_METHOD = 4'b0001,
    CCX_PER_PACKET_METHOD        = 4'b0010,
    CCX_PER_BOUNDARY_METHOD      = 4'b0100,
    CCX_PER_DATA_CREDIT_METHOD   = 4'b1000
  } ccx_method_e;

  typedef enum logic [1:0] {
    CCX_MEM_READ = 2'h0,
    CCX_IO_READ  = 2'h1,
    CCX_IO_WRITE = 2'h2
  } ccx_kind_e;

  typedef struct packed {
    logic [7:0]  tag;
    ccx_kind_e   kind;
    logic [6:0]  addr_low;
    logic [12:0] size;
  } ccx_req_s;

  typedef struct packed {
    logic [7:0]  tag;
    logic [6:0]  lower_addr;
    logic [12:0] length;
    logic        last;
  } ccx_cpl_s;

  typedef struct packed {
    logic [7:0]  req;
    logic [7:0]  hdr;
    logic [13:0] data;
    logic [7:0]  limit;
  } ccx_stat_s;

endpackage : ccx_pkg

//--- hdl/ccx_span_count.sv
// Granule count covered by a byte span: ceil((base mod g + len) / g)
`timescale 1ns/100ps
module ccx_span_count #(
  parameter int OW = 14
) (
  input  wire logic [6:0]    base,
  input  wire logic [12:0]   len,
  input  wire logic [2:0]    log2_g,
  output      logic [OW-1:0] count
);
  logic [13:0] mask;
  logic [13:0] sum;
  logic [13:0] quot;

  always_comb begin
    mask  = (14'h0001 << log2_g) - 14'h0001;
    // Adding mask before the shift rounds any partial granule up
    sum   = {7'h00, base & mask[6:0]} + {1'b0, len} + mask;
    quot  = sum >> log2_g;
    count = quot[OW-1:0];
  end
endmodule : ccx_span_count

//--- hdl/ccx_apb_regs.sv
// APB slave holding the tracker control word and reading its status
`timescale 1ns/100ps
module ccx_apb_regs (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  output      logic [4:0]        ctrl,
  input  wire ccx_pkg::ccx_stat_s stat
);
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic [4:0]  ctrl_r, ctrl_nxt;
  logic        hit;
  logic [31:0] rd;

  always_comb begin
    hit = 1'b1;
    rd  = 32'h0;
    case (paddr)
      ccx_pkg::CCX_OFS_CTRL:  rd = {27'h0, ctrl_r};
      ccx_pkg::CCX_OFS_REQ:   rd = {24'h0, stat.req};
      ccx_pkg::CCX_OFS_HDR:   rd = {24'h0, stat.hdr};
      ccx_pkg::CCX_OFS_DATA:  rd = {18'h0, stat.data};
      ccx_pkg::CCX_OFS_LIMIT: rd = {24'h0, stat.limit};
      default:                hit = 1'b0;
    endcase
    // No wait state: answer is prepared in the setup cycle
    pready_nxt  = psel & ~penable;
    prdata_nxt  = (psel & ~penable & ~pwrite) ? rd : 32'h0;
    pslverr_nxt = psel & ~penable & ~hit;
    ctrl_nxt    = ctrl_r;
    if (psel && penable && pready_r && pwrite &&
        paddr == ccx_pkg::CCX_OFS_CTRL) begin
      ctrl_nxt = pwdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_r    <= ccx_pkg::CCX_CTRL_RST;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign ctrl    = ctrl_r;
endmodule : ccx_apb_regs

//--- hdl/ccx_tracker.sv
// Completion credit tracker gating non-posted requests of the application
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
module ccx_tracker #(
  parameter ccx_pkg::ccx_method_e METHOD =
    ccx_pkg::CCX_PER_PACKET_METHOD,
  parameter int TAG_W      = 8,
  parameter int SCALE_LOG2 = 0,
  parameter bit IO_POLICY  = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic              req_valid,
  input  wire ccx_pkg::ccx_req_s req,
  output      logic              req_grant,
  input  wire logic              cpl_valid,
  input  wire ccx_pkg::ccx_cpl_s cpl
);
  localparam int HW = 8;
  localparam int DW = 14;
  localparam int NE = 1 << TAG_W;

  // ****************************************
  // Configuration decode
  // ****************************************
  logic [4:0]         ctrl;
  ccx_pkg::ccx_stat_s stat;
  logic [2:0]         rcb_log2;
  logic [3:0]         mrs_log2;
  logic [2:0]         g_log2;
  logic [15:0]        data_bytes;
  logic [DW-1:0]      total_data;
  logic [2:0]         mrs_field;

  always_comb begin
    // 0 selects 64 bytes; reset value keeps the default
    rcb_log2 = ccx_pkg::CCX_RCB_LOG2_MIN +
               {2'h0, ctrl[ccx_pkg::CCX_CTRL_RCB]};
    mrs_field = ctrl[ccx_pkg::CCX_CTRL_MRS +: 3];
    // Reserved codes fall back to 128 bytes, the safe smallest size
    if (mrs_field > ccx_pkg::CCX_MRS_FIELD_MAX) begin
      mrs_field = 3'h0;
    end
    mrs_log2 = ccx_pkg::CCX_MRS_LOG2_MIN + {1'b0, mrs_field};
    // Finer granules multiply every data figure alike
    g_log2 = ccx_pkg::CCX_CRED_LOG2 - 3'(SCALE_LOG2);
    data_bytes = ctrl[ccx_pkg::CCX_CTRL_PERF] ?
                 ccx_pkg::CCX_DATA_BYTES_HIGH :
                 ccx_pkg::CCX_DATA_BYTES_GOOD;
    total_data = DW'(data_bytes >> g_log2);
  end

  // ****************************************
  // Request needs
  // ****************************************
  logic [HW-1:0] req_hdr_need;
  logic [DW-1:0] req_data_span;
  logic [DW-1:0] req_data_need;
  logic [HW-1:0] cpl_hdr_cross;
  logic [DW-1:0] cpl_data_cross;

  ccx_span_count #(.OW(HW)) u_req_hdr (
    .base   (req.addr_low),
    .len    (req.size),
    .log2_g (rcb_log2),
    .count  (req_hdr_need)
  );

  ccx_span_count #(.OW(DW)) u_req_data (
    .base   (req.addr_low),
    .len    (req.size),
    .log2_g (g_log2),
    .count  (req_data_span)
  );

  // Closed-form counts stand in for a stepping address counter
  ccx_span_count #(.OW(HW)) u_cpl_hdr (
    .base   (cpl.lower_addr),
    .len    (cpl.length),
    .log2_g (rcb_log2),
    .count  (cpl_hdr_cross)
  );

  ccx_span_count #(.OW(DW)) u_cpl_data (
    .base   (cpl.lower_addr),
    .len    (cpl.length),
    .log2_g (g_log2),
    .count  (cpl_data_cross)
  );

  always_comb begin
    req_data_need = req_data_span;
    case (METHOD)
      ccx_pkg::CCX_PER_BOUNDARY_METHOD: begin
        // Credits per boundary is 2^(rcb - granule): 4 for 64 bytes
        req_data_need = DW'({6'h0, req_hdr_need} <<
                        (rcb_log2 - g_log2));
        if (IO_POLICY && req.kind == ccx_pkg::CCX_IO_READ) begin
          req_data_need = DW'(1);
        end
      end
      default: begin
        req_data_need = req_data_span;
      end
    endcase
    if (req.kind == ccx_pkg::CCX_IO_WRITE) begin
      req_data_need = '0;
    end
  end

  // ****************************************
  // Per-tag memory of reserved amounts
  // ****************************************
  logic [HW-1:0]       mem_hdr_r  [NE];
  logic [DW-1:0]       mem_data_r [NE];
  ccx_pkg::ccx_kind_e  mem_kind_r [NE];
  logic                grant_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < NE; gi++) begin : g_tag
      logic [HW-1:0]      hdr_nxt;
      logic [DW-1:0]      data_nxt;
      ccx_pkg::ccx_kind_e kind_nxt;
      always_comb begin
        hdr_nxt  = mem_hdr_r[gi];
        data_nxt = mem_data_r[gi];
        kind_nxt = mem_kind_r[gi];
        if (grant_nxt && req.tag[TAG_W-1:0] == TAG_W'(gi)) begin
          hdr_nxt  = req_hdr_need;
          data_nxt = req_data_need;
          kind_nxt = req.kind;
        end
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          mem_hdr_r[gi]  <= '0;
          mem_data_r[gi] <= '0;
          mem_kind_r[gi] <= ccx_pkg::CCX_MEM_READ;
        end else begin
          mem_hdr_r[gi]  <= hdr_nxt;
          mem_data_r[gi] <= data_nxt;
          mem_kind_r[gi] <= kind_nxt;
        end
      end
    end
  endgenerate

  // ****************************************
  // Outstanding limit
  // ****************************************
  logic [HW-1:0] limit_r, limit_nxt;
  logic [HW-1:0] lim_data;
  logic [HW-1:0] lim_hdr;

  always_comb begin
    // Sizes are powers of two, so each floor is a shift
    lim_data = HW'(data_bytes >> mrs_log2);
    lim_hdr  = HW'(ccx_pkg::CCX_TOTAL_HDR >>
               (mrs_log2 - {1'b0, rcb_log2}));
    limit_nxt = (lim_data < lim_hdr) ? lim_data : lim_hdr;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      limit_r <= '0;
    end else begin
      limit_r <= limit_nxt;
    end
  end

  // ****************************************
  // Pending accounting and grant
  // ****************************************
  logic [HW-1:0] pend_req_r, pend_req_nxt;
  logic [HW-1:0] pend_hdr_r, pend_hdr_nxt;
  logic [DW-1:0] pend_data_r, pend_data_nxt;
  logic          grant_r;
  logic [HW-1:0] add_hdr, rel_hdr;
  logic [DW-1:0] add_data, rel_data;
  logic [HW-1:0] add_req, rel_req;
  logic [HW:0]   sum_hdr;
  logic [DW:0]   sum_data;
  logic [HW:0]   sum_req;
  logic [HW:0]   acc_hdr;
  logic [DW:0]   acc_data;
  logic          fits;
  logic [TAG_W-1:0] ctag;

  always_comb begin
    ctag = cpl.tag[TAG_W-1:0];
    sum_hdr  = {1'b0, pend_hdr_r} + {1'b0, req_hdr_need};
    sum_data = {1'b0, pend_data_r} + {1'b0, req_data_need};
    case (METHOD)
      ccx_pkg::CCX_OUTSTANDING_LIMIT_METHOD: begin
        fits = pend_req_r < limit_r;
      end
      default: begin
        fits = (sum_hdr <= ccx_pkg::CCX_TOTAL_HDR) &&
               (sum_data <= {1'b0, total_data});
      end
    endcase
    // The requester holds its request until the grant pulse, so no
    // second grant is given in the pulse cycle
    grant_nxt = req_valid & ~grant_r & fits;

    add_req  = grant_nxt ? HW'(1) : '0;
    // The limit method reserves by count alone, so credit sums cannot wrap
    add_hdr  = '0;
    add_data = '0;
    if (grant_nxt && METHOD != ccx_pkg::CCX_OUTSTANDING_LIMIT_METHOD) begin
      add_hdr  = req_hdr_need;
      add_data = req_data_need;
    end
    // Every final completion ends one request, whatever the method
    rel_req  = (cpl_valid && cpl.last) ? HW'(1) : '0;
    rel_hdr  = '0;
    rel_data = '0;
    if (cpl_valid) begin
      case (METHOD)
        ccx_pkg::CCX_OUTSTANDING_LIMIT_METHOD: begin
          rel_req = cpl.last ? HW'(1) : '0;
        end
        ccx_pkg::CCX_PER_PACKET_METHOD: begin
          if (cpl.last) begin
            rel_hdr  = mem_hdr_r[ctag];
            rel_data = mem_data_r[ctag];
          end
        end
        ccx_pkg::CCX_PER_BOUNDARY_METHOD: begin
          rel_hdr  = cpl_hdr_cross;
          rel_data = DW'({6'h0, cpl_hdr_cross} << (rcb_log2 - g_log2));
          if (IO_POLICY && mem_kind_r[ctag] != ccx_pkg::CCX_MEM_READ) begin
            rel_hdr  = HW'(1);
            rel_data = mem_data_r[ctag];
          end
        end
        ccx_pkg::CCX_PER_DATA_CREDIT_METHOD: begin
          rel_hdr  = cpl_hdr_cross;
          rel_data = (cpl.length == 13'h0) ? '0 :
                     cpl_data_cross;
        end
        default: begin
          rel_req = '0;
        end
      endcase
    end
    // Release saturates at zero so a stray completion cannot wrap
    sum_req = {1'b0, pend_req_r} + {1'b0, add_req};
    pend_req_nxt  = (sum_req > {1'b0, rel_req}) ?
                    HW'(sum_req - {1'b0, rel_req}) : '0;
    acc_hdr  = {1'b0, pend_hdr_r} + {1'b0, add_hdr};
    acc_data = {1'b0, pend_data_r} + {1'b0, add_data};
    pend_hdr_nxt  = (acc_hdr > {1'b0, rel_hdr}) ?
                    HW'(acc_hdr - {1'b0, rel_hdr}) : '0;
    pend_data_nxt = (acc_data > {1'b0, rel_data}) ?
                    DW'(acc_data - {1'b0, rel_data}) : '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_req_r  <= '0;
      pend_hdr_r  <= '0;
      pend_data_r <= '0;
      grant_r     <= 1'b0;
    end else begin
      pend_req_r  <= pend_req_nxt;
      pend_hdr_r  <= pend_hdr_nxt;
      pend_data_r <= pend_data_nxt;
      grant_r     <= grant_nxt;
    end
  end

  assign req_grant = grant_r;

  // ****************************************
  // Register access
  // ****************************************
  always_comb begin
    stat.req   = pend_req_r;
    stat.hdr   = pend_hdr_r;
    stat.data  = pend_data_r;
    stat.limit = limit_r;
  end

  ccx_apb_regs u_regs (
    .clk     (clk),
    .rst_b   (rst_b),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ctrl    (ctrl),
    .stat    (stat)
  );
endmodule : ccx_tracker

//--- dv/ccx_tracker_props.sv
// Port-level assertions of the completion credit tracker
`timescale 1ns/100ps
module ccx_tracker_props (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              req_valid,
  input wire ccx_pkg::ccx_req_s req,
  input wire logic              req_grant,
  input wire logic              cpl_valid,
  input wire ccx_pkg::ccx_cpl_s cpl
);
  // ****************************************
  // Shadow of the control word
  // ****************************************
  logic       acc;
  logic [4:0] ctrl_r;
  logic [4:0] ctrl_nxt;
  assign acc = psel && penable && pready;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (acc && pwrite && paddr == ccx_pkg::CCX_OFS_CTRL) begin
      ctrl_nxt = pwdata[4:0];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= ccx_pkg::CCX_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property
    (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside first access cycle");
  a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_slverr_map: assert property (acc && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > ccx_pkg::CCX_OFS_LIMIT))
    else $error("error flag does not match map");
  a_grant_pulse: assert property (req_grant |=> !req_grant)
    else $error("grant longer than one cycle");
  a_grant_cause: assert property ($rose(req_grant) |->
    $past(req_valid))
    else $error("grant without request");
  a_ctrl_readback: assert property (acc && !pwrite
    && paddr == ccx_pkg::CCX_OFS_CTRL |-> prdata == {27'h0, ctrl_r})
    else $error("control word read back wrong");
  a_hdr_bound: assert property (acc && !pwrite
    && paddr == ccx_pkg::CCX_OFS_HDR |-> prdata <= 32'h40)
    else $error("pending headers above total");
  a_data_bound: assert property (acc && !pwrite
    && paddr == ccx_pkg::CCX_OFS_DATA |-> prdata <= 32'h3e0)
    else $error("pending data above total");
  cover property (req_grant);
  cover property (cpl_valid && cpl.last);
  cover property (pslverr);
  cover property ((req_valid && !req_grant) [*8]);
endmodule : ccx_tracker_props

//--- dv/ccx_dev_model.sv
// Endpoint receive side: returns completions on command, watches space
`timescale 1ns/100ps
module ccx_dev_model (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              req_grant,
  output      logic              cpl_valid,
  output      ccx_pkg::ccx_cpl_s cpl,
  output      logic              overflow
);
  // Completion headers held by the receive buffer
  localparam int HDR_SLOTS = 64;
  int outstanding;
  initial begin
    cpl_valid = 1'b0;
    cpl = '0;
    overflow = 1'b0;
  end
  // Every granted request takes at least one header slot
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outstanding <= 0;
    end else begin
      outstanding <= outstanding + (req_grant ? 1 : 0)
        - ((cpl_valid && cpl.last) ? 1 : 0);
      if (outstanding > HDR_SLOTS) begin
        overflow <= 1'b1;
      end
    end
  end
  task automatic complete(input logic [7:0] t, input logic [6:0] la,
                          input logic [12:0] len, input logic last);
    @(posedge clk);
    cpl_valid <= 1'b1;
    cpl <= '{tag: t, lower_addr: la, length: len, last: last};
    @(posedge clk);
    cpl_valid <= 1'b0;
    // Idle header fields flip so stale values are never mistaken
    cpl <= ~cpl;
  endtask : complete
endmodule : ccx_dev_model

//--- dv/testbench.sv
// Self-checking bench of the tracker in its per-packet method
`timescale 1ns/100ps
module testbench;
  logic              clk;
  logic              rst_b;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              req_valid;
  ccx_pkg::ccx_req_s req;
  logic              req_grant;
  logic              cpl_valid;
  ccx_pkg::ccx_cpl_s cpl;
  logic              overflow;
  logic [31:0]       rd;
  logic              er;
  logic              g;
  int                errors;
  int                comparisons;
  int                cycles;
  ccx_tracker uut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req(req), .req_grant(req_grant), .cpl_valid(cpl_valid), .cpl(cpl)
  );
  ccx_dev_model dev (
    .clk(clk), .rst_b(rst_b), .req_grant(req_grant),
    .cpl_valid(cpl_valid), .cpl(cpl), .overflow(overflow)
  );
  task automatic test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Pending header and data credits as software sees them
  task automatic counts(input logic [31:0] h, input logic [31:0] d);
    apb(1'b0, ccx_pkg::CCX_OFS_HDR, 32'h0);
    chk("hdr", rd, h);
    apb(1'b0, ccx_pkg::CCX_OFS_DATA, 32'h0);
    chk("data", rd, d);
  endtask : counts
  task automatic await(input int n);
    g = 1'b0;
    for (int i = 0; i < n && g !== 1'b1; i++) begin
      @(posedge clk);
      if (req_grant === 1'b1) begin
        g = 1'b1;
        req_valid <= 1'b0;
      end
    end
  endtask : await
  // Request stays up until granted; a refused one is left pending
  task automatic send(input logic [7:0] t, input ccx_pkg::ccx_kind_e k,
                      input logic [6:0] a, input logic [12:0] s);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{tag: t, kind: k, addr_low: a, size: s};
    await(20);
  endtask : send
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles > 5000) begin
        errors++;
        test_done();
      end
    end
  end
  initial begin
    errors = 0;
    comparisons = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_valid = 1'b0;
    req = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, ccx_pkg::CCX_OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    counts(32'h0, 32'h0);
    // Two headers per 128-byte read at 64-byte boundary: 32 requests
    apb(1'b0, ccx_pkg::CCX_OFS_LIMIT, 32'h0);
    chk("limit", rd, 32'h20);
    apb(1'b0, 8'h14, 32'h0);
    chk("hole", rd, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    send(8'h01, ccx_pkg::CCX_MEM_READ, 7'h7c, 13'h0008);
    chk("grant", {31'h0, g}, 32'h1);
    counts(32'h2, 32'h2);
    send(8'h02, ccx_pkg::CCX_IO_WRITE, 7'h00, 13'h0004);
    counts(32'h3, 32'h2);
    apb(1'b1, ccx_pkg::CCX_OFS_CTRL, 32'hffffffff);
    apb(1'b0, ccx_pkg::CCX_OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1f);
    // Reserved size code means 128 bytes: one header each, 64 requests
    apb(1'b0, ccx_pkg::CCX_OFS_LIMIT, 32'h0);
    chk("limit", rd, 32'h40);
    // Span 3ch..43h needs one header at 128 bytes, two at 64
    send(8'h03, ccx_pkg::CCX_MEM_READ, 7'h3c, 13'h0008);
    counts(32'h4, 32'h4);
    apb(1'b0, ccx_pkg::CCX_OFS_REQ, 32'h0);
    chk("requests", rd, 32'h3);
    dev.complete(8'h01, 7'h7c, 13'h0004, 1'b0);
    counts(32'h4, 32'h4);
    dev.complete(8'h01, 7'h00, 13'h0004, 1'b1);
    counts(32'h2, 32'h2);
    dev.complete(8'h02, 7'h00, 13'h0000, 1'b1);
    dev.complete(8'h03, 7'h3c, 13'h0008, 1'b1);
    counts(32'h0, 32'h0);
    apb(1'b0, ccx_pkg::CCX_OFS_REQ, 32'h0);
    chk("requests", rd, 32'h0);
    apb(1'b1, ccx_pkg::CCX_OFS_CTRL, 32'h0000000a);
    send(8'h04, ccx_pkg::CCX_MEM_READ, 7'h00, 13'h1000);
    counts(32'h40, 32'h100);
    send(8'h05, ccx_pkg::CCX_MEM_READ, 7'h00, 13'h0040);
    chk("refused", {31'h0, g}, 32'h0);
    dev.complete(8'h04, 7'h00, 13'h1000, 1'b1);
    await(20);
    chk("late grant", {31'h0, g}, 32'h1);
    counts(32'h1, 32'h4);
    dev.complete(8'h05, 7'h00, 13'h0040, 1'b1);
    counts(32'h0, 32'h0);
    chk("overflow", {31'h0, overflow}, 32'h0);
    test_done();
  end
endmodule : testbench
bind ccx_tracker ccx_tracker_props u_props (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
  .req(req), .req_grant(req_grant), .cpl_valid(cpl_valid), .cpl(cpl)
);
